// ### core/atf_pkg.sv
// Purpose : shared constants and types of the task-file register set
// Assumes : one device clock, synchronous active-high reset
// Notes   : register selects decode the parallel chip-select / address pins
package atf_pkg;
   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int         DATA_W       = 16;
   localparam int         BYTE_W       = 8;
   localparam logic [7:0] SECT_CNT_RST = 8'h01;
   localparam logic [7:0] SECT_NUM_RST = 8'h01;
   localparam logic [7:0] DEVHEAD_RST  = 8'ha0;
   localparam logic [7:0] STATUS_RST   = 8'h50;
   localparam logic [7:0] DIAG_OK      = 8'h01;
   localparam logic [7:0] ERR_MASK     = 8'hd7;
   localparam logic [8:0] FULL_XFER    = 9'h100;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTL_SOFT_RESET_BIT = 2;
   localparam int CTL_NIEN = 1;
   localparam int DH_LBA   = 6;
   localparam int DH_DEV   = 4;
   localparam int ST_DSC   = 4;
   localparam int DA_WTG   = 6;
   localparam int DA_HIZ   = 7;
   // ---------------------------------------------------------------
   // register selects
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      SEL_NONE    = 4'b0000,
      SEL_DATA    = 4'b0001,
      SEL_ERR     = 4'b0010,
      SEL_COUNT   = 4'b0011,
      SEL_SECT    = 4'b0100,
      SEL_CYL_LO  = 4'b0101,
      SEL_CYL_HI  = 4'b0110,
      SEL_DEVHEAD = 4'b0111,
      SEL_STATUS  = 4'b1000,
      SEL_CTL     = 4'b1001,
      SEL_DRVADDR = 4'b1010
   } atf_sel_type;

   function automatic atf_sel_type atf_decode(input logic cs0_n, input logic cs1_n,
                                              input logic [2:0] da);
      atf_sel_type s;
      s = SEL_NONE;
      if (!cs0_n && cs1_n) begin
         s = atf_sel_type'({1'b0, da} + 4'h1);
      end else if (cs0_n && !cs1_n && da[2:1] == 2'b11) begin
         s = da[0] ? SEL_DRVADDR : SEL_CTL;
      end
      return s;
   endfunction
endpackage

// ### core/atf_dport_if.sv
// Purpose : carrier between register front end and data port
// Assumes : all signals in the device clock domain
// Notes   : pop and push are one-cycle pulses at strobe end
interface atf_dport_if;
   logic        rd_pop;
   logic        wr_push;
   logic [15:0] host_wdata;
   logic [15:0] rd_word;
   logic        data_request_flag;
   logic        byte_mode;
   modport front (output rd_pop, output wr_push, output host_wdata, output byte_mode,
                  input rd_word, input data_request_flag);
   modport port  (input rd_pop, input wr_push, input host_wdata, input byte_mode,
                  output rd_word, output data_request_flag);
endinterface

// ### core/atf_data_port.sv
// Purpose : pio data word holding stage between host and sector buffer
// Assumes : core picks direction and byte mode before enabling transfer
// Notes   : one word of holding; the buffer stalls through src_ready
module atf_data_port
   import atf_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // front end
   atf_dport_if.port        p,
   // core side
   input  wire logic        xfer_en,
   input  wire logic        to_host,
   input  wire logic [15:0] src_data,
   input  wire logic        src_valid,
   output      logic        src_ready,
   output      logic [15:0] sink_data,
   output      logic        sink_valid,
   input  wire logic        sink_ready
);
   logic [15:0] word_q;
   logic        full_q;
   logic [15:0] mask;

   assign mask      = p.byte_mode ? 16'h00ff : 16'hffff;
   assign src_ready = xfer_en && to_host && !full_q;
   assign p.data_request_flag     = xfer_en && (to_host ? full_q : sink_ready);
   assign p.rd_word = word_q & mask;

   always_ff @(posedge clk) begin
      if (rst) begin
         full_q <= 1'b0;
         word_q <= 16'h0000;
      end else if (src_valid && src_ready) begin
         full_q <= 1'b1;
         word_q <= src_data;
      end else if (p.rd_pop && full_q) begin
         full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sink_valid <= 1'b0;
         sink_data  <= 16'h0000;
      end else begin
         sink_valid <= p.wr_push && p.data_request_flag && !to_host;
         if (p.wr_push && p.data_request_flag) begin
            sink_data <= p.host_wdata & mask;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   pop_needs_word_a: assert property (p.rd_pop && to_host |-> p.data_request_flag)
      else $error("data popped while no word held");
   byte_upper_zero_a: assert property (p.byte_mode |-> p.rd_word[15:8] == 8'h00)
      else $error("byte transfer drives upper byte");
endmodule

// ### core/atf_irq_ctl.sv
// Purpose : pending interrupt and its gating onto the request pin
// Assumes : status read pulse is one cycle
// Notes   : an event in the acknowledge cycle stays pending
module atf_irq_ctl (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // events
   input  wire logic done_stb,
   input  wire logic data_request_flag,
   input  wire logic status_rd,
   // gating
   input  wire logic int_dis_n,
   input  wire logic selected,
   output      logic intrq
);
   logic drq_q;
   logic pend_q;
   logic evt;

   assign evt = done_stb || (data_request_flag && !drq_q);

   always_ff @(posedge clk) begin
      if (rst) begin
         drq_q  <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         drq_q <= data_request_flag;
         if (evt) begin
            pend_q <= 1'b1;
         end else if (status_rd) begin
            pend_q <= 1'b0;
         end
      end
   end

   assign intrq = pend_q && !int_dis_n && selected;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ack_clears_a: assert property (status_rd && !evt |=> !intrq)
      else $error("interrupt survives status read");
   done_raises_a: assert property (done_stb ##1 (!int_dis_n && selected) |-> intrq)
      else $error("completion did not raise interrupt");
endmodule

// ### core/atf_task_file.sv
// Purpose : host-visible task-file registers of a disk device
// Assumes : host pins sampled synchronously; one device clock
// Notes   : accesses take effect at strobe release
module atf_task_file
   import atf_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // host register pins
   input  wire logic        cs0_n,
   input  wire logic        cs1_n,
   input  wire logic [2:0]  da,
   input  wire logic        dior_n,
   input  wire logic        diow_n,
   input  wire logic [15:0] dd_in,
   output      logic [15:0] dd_out,
   output      logic [15:0] dd_oe,
   output      logic        intrq,
   // strap
   input  wire logic        dev_id,
   // command to core
   output      logic [7:0]  cmd_code,
   output      logic        cmd_stb,
   output      logic [7:0]  feature,
   output      logic [8:0]  xfer_sectors,
   output      logic [7:0]  sect_num,
   output      logic        lba_mode,
   output      logic        soft_reset,
   // completion and state from core
   input  wire logic        core_busy,
   input  wire logic        core_ready,
   input  wire logic        done_stb,
   input  wire logic        done_err,
   input  wire logic [7:0]  done_err_bits,
   input  wire logic [3:0]  done_head,
   input  wire logic [7:0]  done_sect,
   input  wire logic [7:0]  done_count,
   input  wire logic        diag_stb,
   input  wire logic [7:0]  diag_code,
   input  wire logic        fault_evt,
   input  wire logic        seek_done,
   input  wire logic        standby,
   input  wire logic        index_pulse,
   input  wire logic        write_gate,
   // data path
   input  wire logic        xfer_en,
   input  wire logic        to_host,
   input  wire logic        byte_mode,
   input  wire logic [15:0] src_data,
   input  wire logic        src_valid,
   output      logic        src_ready,
   output      logic [15:0] sink_data,
   output      logic        sink_valid,
   input  wire logic        sink_ready
);
   // ---------------------------------------------------------------
   // strobes and decode
   // ---------------------------------------------------------------
   atf_dport_if dp ();
   atf_sel_type sel;
   logic        dior_n_q, diow_n_q, rd_end, wr_end, ireset;
   logic        soft_reset_bit_q, nien_q, busy, selected, status_rd;
   logic [7:0]  devhead_q, count_q, sect_q, err_q, feat_q, cmd_q, status, drv_addr;
   logic        df_q, dsc_q, err_hold_q, err_bit_q, idx_q, cmd_stb_q;
   logic [15:0] rd_mux, rd_data_q;

   assign sel       = atf_decode(cs0_n, cs1_n, da);
   assign rd_end    = !dior_n_q && dior_n;
   assign wr_end    = !diow_n_q && diow_n;
   assign ireset    = rst || soft_reset_bit_q;
   assign busy      = core_busy || soft_reset_bit_q;
   assign selected  = devhead_q[DH_DEV] == dev_id;
   assign status_rd = rd_end && selected && (sel == SEL_STATUS);

   always_ff @(posedge clk) begin
      if (rst) begin
         dior_n_q <= 1'b1;
         diow_n_q <= 1'b1;
      end else begin
         dior_n_q <= dior_n;
         diow_n_q <= diow_n;
      end
   end

   // ---------------------------------------------------------------
   // device control
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         soft_reset_bit_q <= 1'b0;
         nien_q <= 1'b0;
      end else if (wr_end && sel == SEL_CTL) begin
         soft_reset_bit_q <= dd_in[CTL_SOFT_RESET_BIT];
         nien_q <= dd_in[CTL_NIEN];
      end
   end

   // ---------------------------------------------------------------
   // command block registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (ireset) begin
         devhead_q <= DEVHEAD_RST;
         count_q   <= SECT_CNT_RST;
         sect_q    <= SECT_NUM_RST;
         feat_q    <= 8'h00;
         cmd_q     <= 8'h00;
         cmd_stb_q <= 1'b0;
      end else begin
         cmd_stb_q <= 1'b0;
         if (done_stb) begin
            devhead_q[3:0] <= done_head;
            count_q        <= done_count;
            sect_q         <= done_sect;
         end else if (wr_end && !busy) begin
            unique case (sel)
               SEL_ERR:     feat_q <= dd_in[7:0];
               SEL_COUNT:   count_q <= dd_in[7:0];
               SEL_SECT:    sect_q <= dd_in[7:0];
               SEL_DEVHEAD: devhead_q <= dd_in[7:0] | 8'ha0;
               SEL_STATUS: begin
                  if (selected) begin
                     cmd_q     <= dd_in[7:0];
                     cmd_stb_q <= 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // error register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (ireset) begin
         err_q <= DIAG_OK;
      end else if (diag_stb) begin
         err_q <= diag_code;
      end else if (done_stb) begin
         err_q <= done_err_bits & ERR_MASK;
      end
   end

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (ireset) begin
         df_q       <= 1'b0;
         err_bit_q  <= 1'b0;
         err_hold_q <= 1'b0;
         dsc_q      <= STATUS_RST[ST_DSC];
         idx_q      <= 1'b0;
      end else begin
         idx_q <= index_pulse;
         if (fault_evt) begin
            df_q <= 1'b1;
         end else if (status_rd) begin
            df_q <= 1'b0;
         end
         if (done_stb && done_err) begin
            err_bit_q <= 1'b1;
         end else if (cmd_stb_q) begin
            err_bit_q <= 1'b0;
         end
         if (done_stb && done_err) begin
            err_hold_q <= 1'b1;
         end else if (status_rd) begin
            err_hold_q <= 1'b0;
         end
         if (standby) begin
            dsc_q <= 1'b1;
         end else if (!err_hold_q || status_rd) begin
            dsc_q <= seek_done;
         end
      end
   end

   // corrected-data bit is tied low; ready waits for the core after power-up
   assign status = {busy, core_ready && !soft_reset_bit_q, df_q, dsc_q, dp.data_request_flag, 1'b0, idx_q,
                    err_bit_q};
   assign drv_addr = {1'b0, !write_gate, ~devhead_q[3:0],
                      !(devhead_q[DH_DEV] && core_ready),
                      !(!devhead_q[DH_DEV] && core_ready)};

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always_comb begin
      rd_mux = 16'h0000;
      if (busy) begin
         rd_mux = {8'h00, status};
      end else begin
         unique case (sel)
            SEL_DATA:    rd_mux = dp.rd_word;
            SEL_ERR:     rd_mux = {8'h00, err_q};
            SEL_COUNT:   rd_mux = {8'h00, count_q};
            SEL_SECT:    rd_mux = {8'h00, sect_q};
            SEL_DEVHEAD: rd_mux = {8'h00, devhead_q};
            SEL_STATUS:  rd_mux = {8'h00, status};
            SEL_CTL:     rd_mux = {8'h00, status};
            SEL_DRVADDR: rd_mux = {8'h00, drv_addr};
            default:     rd_mux = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q <= 16'h0000;
      end else begin
         rd_data_q <= rd_mux;
      end
   end

   // the top bit of the drive address readback is left floating so the other device can own it
   always_comb begin
      dd_oe = 16'h0000;
      if (!dior_n && selected && sel != SEL_NONE) begin
         if (sel == SEL_DATA && !busy) begin
            dd_oe = 16'hffff;
         end else if (sel == SEL_DRVADDR && !busy) begin
            dd_oe = 16'h007f;
         end else begin
            dd_oe = 16'h00ff;
         end
      end
   end

   assign dd_out = rd_data_q;

   // ---------------------------------------------------------------
   // data port and interrupt
   // ---------------------------------------------------------------
   assign dp.rd_pop     = rd_end && selected && !busy && sel == SEL_DATA;
   assign dp.wr_push    = wr_end && selected && !busy && sel == SEL_DATA;
   assign dp.host_wdata = dd_in;
   assign dp.byte_mode  = byte_mode;

   atf_data_port u_dport (
      .clk        (clk),
      .rst        (ireset),
      .p          (dp.port),
      .xfer_en    (xfer_en),
      .to_host    (to_host),
      .src_data   (src_data),
      .src_valid  (src_valid),
      .src_ready  (src_ready),
      .sink_data  (sink_data),
      .sink_valid (sink_valid),
      .sink_ready (sink_ready)
   );

   atf_irq_ctl u_irq (
      .clk       (clk),
      .rst       (ireset),
      .done_stb  (done_stb),
      .data_request_flag       (dp.data_request_flag),
      .status_rd (status_rd),
      .int_dis_n (nien_q),
      .selected  (selected),
      .intrq     (intrq)
   );

   // ---------------------------------------------------------------
   // outputs to core
   // ---------------------------------------------------------------
   assign cmd_code     = cmd_q;
   assign cmd_stb      = cmd_stb_q;
   assign feature      = feat_q;
   assign sect_num     = sect_q;
   assign lba_mode     = devhead_q[DH_LBA];
   assign soft_reset   = soft_reset_bit_q;
   assign xfer_sectors = (count_q == 8'h00) ? FULL_XFER : {1'b0, count_q};

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence cmd_written_s;
      wr_end && !busy && selected && sel == SEL_STATUS;
   endsequence
   sequence err_done_s;
      done_stb && done_err;
   endsequence
   soft_reset_bit_busy_a: assert property (soft_reset_bit_q |-> status[7] && !status[6])
      else $error("soft reset not reported busy");
   irq_disabled_a: assert property (nien_q || !selected |-> !intrq)
      else $error("interrupt while disabled");
   count_full_a: assert property (count_q == 8'h00 |-> xfer_sectors == 9'h100)
      else $error("zero count not full transfer");
   err_layout_a: assert property (done_stb && !diag_stb |=> !err_q[5] && !err_q[3])
      else $error("reserved error bits set");
   cmd_clears_err_a: assert property (cmd_written_s ##1 !err_done_s |=> !err_bit_q)
      else $error("error bit not cleared by command");
   busy_read_a: assert property (busy && !dior_n && !soft_reset_bit_q |=> dd_out[7] == 1'b1)
      else $error("busy read did not return status");
   dsc_frozen_a: assert property (err_done_s ##1 (!status_rd && !standby) |=>
                                  $stable(dsc_q))
      else $error("seek flag moved during error hold");
   df_clear_a: assert property (status_rd && !fault_evt |=> !df_q)
      else $error("fault flag survives status read");
   head_update_a: assert property (done_stb |=> devhead_q[3:0] == $past(done_head))
      else $error("head bits not updated at completion");
   dh_fixed_a: assert property (devhead_q[7] && devhead_q[5])
      else $error("fixed device/head bits low");
endmodule

// ### verification/atf_host_model.sv
// Purpose : host adapter model driving the parallel register pins
// Assumes : pins change just after a rising clock edge
// Notes   : released data lines show the inverse of the last value
module atf_host_model
   import atf_pkg::*;
(
   // clock
   input  wire logic        clk,
   // register pins
   output      logic        cs0_n,
   output      logic        cs1_n,
   output      logic [2:0]  da,
   output      logic        dior_n,
   output      logic        diow_n,
   output      logic [15:0] dd_in,
   // answer
   input  wire logic [15:0] dd_out,
   input  wire logic [15:0] dd_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cs0_n  = 1'b1;
      cs1_n  = 1'b1;
      da     = 3'h0;
      dior_n = 1'b1;
      diow_n = 1'b1;
      dd_in  = 16'h0000;
   end

   // ---------------------------------------------------------------
   // one register access, strobe held three cycles
   // ---------------------------------------------------------------
   task automatic acc(input logic wr, input logic ctl, input logic [2:0] a,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output logic [15:0] oe);
      @(posedge clk);
      cs0_n <= ctl;
      cs1_n <= !ctl;
      da    <= a;
      if (wr) begin
         dd_in  <= wd;
         diow_n <= 1'b0;
      end else begin
         dior_n <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
      rd = dd_out;
      oe = dd_oe;
      // strobe released only after the answer is taken
      @(posedge clk);
      dior_n <= 1'b1;
      diow_n <= 1'b1;
      @(posedge clk);
      cs0_n <= 1'b1;
      cs1_n <= 1'b1;
      dd_in <= ~wd;
      // one idle edge, so that what the release edge did has landed on return
      @(posedge clk);
   endtask

   // soft reset bit stays set 5 us = 1250 cycles before it is cleared
   task automatic hold_reset();
      repeat (1250) @(posedge clk);
   endtask
endmodule

// ### verification/testbench.sv
// Purpose : self-checking bench of the task-file register set
// Assumes : core side driven directly by the bench
// Notes   : expected values worked out from the register layout
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import atf_pkg::*;

   logic clk = 1'b0, rst = 1'b1;
   logic cs0_n, cs1_n, dior_n, diow_n, intrq, cmd_stb, lba_mode, soft_reset;
   logic [2:0] da;
   logic [15:0] dd_in, dd_out, dd_oe, sink_data, sink_cap;
   logic [7:0] cmd_code, feature, sect_num;
   logic [8:0] xfer_sectors;
   logic core_busy = 0, core_ready = 1, done_stb = 0, done_err = 0, fault_evt = 0;
   logic seek_done = 1, write_gate = 0, xfer_en = 0, to_host = 0, byte_mode = 0;
   logic src_valid = 0, src_ready, sink_valid, sink_ready = 0;
   logic index_pulse = 0, standby = 0, diag_stb = 0;
   logic [7:0] done_err_bits = 0, done_sect = 8'h44, done_count = 0;
   logic [3:0] done_head = 4'h9;
   logic [15:0] src_data = 16'h0000;
   int miscompares = 0, checks_done = 0, stb_cnt = 0;

   always #2 clk = ~clk;

   atf_host_model i_host (.clk(clk), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da),
      .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe));

   atf_task_file i_dut (.clk(clk), .rst(rst), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da),
      .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe),
      .intrq(intrq), .dev_id(1'b0), .cmd_code(cmd_code), .cmd_stb(cmd_stb),
      .feature(feature), .xfer_sectors(xfer_sectors), .sect_num(sect_num),
      .lba_mode(lba_mode), .soft_reset(soft_reset), .core_busy(core_busy),
      .core_ready(core_ready), .done_stb(done_stb), .done_err(done_err),
      .done_err_bits(done_err_bits), .done_head(done_head), .done_sect(done_sect),
      .done_count(done_count), .diag_stb(diag_stb), .diag_code(8'h81),
      .fault_evt(fault_evt), .seek_done(seek_done), .standby(standby),
      .index_pulse(index_pulse), .write_gate(write_gate), .xfer_en(xfer_en),
      .to_host(to_host), .byte_mode(byte_mode), .src_data(src_data),
      .src_valid(src_valid), .src_ready(src_ready), .sink_data(sink_data),
      .sink_valid(sink_valid), .sink_ready(sink_ready));

   // one-cycle pulses caught mid-cycle, away from the edge that launches them
   always @(negedge clk) begin
      if (cmd_stb === 1'b1) stb_cnt++;
      if (sink_valid === 1'b1) sink_cap <= sink_data;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // masking with the enables also checks which bits are driven
   task automatic rd(input logic ctl, input logic [2:0] a, input logic [15:0] exp,
                     input string n);
      logic [15:0] d, oe;
      i_host.acc(1'b0, ctl, a, 16'h0000, d, oe);
      check(n, d & oe, exp);
   endtask

   task automatic wr(input logic ctl, input logic [2:0] a, input logic [15:0] wd);
      logic [15:0] d, oe;
      i_host.acc(1'b1, ctl, a, wd, d, oe);
   endtask

   task automatic done(input logic e, input logic [7:0] eb, input logic [7:0] c);
      @(posedge clk);
      done_stb      <= 1'b1;
      done_err      <= e;
      done_err_bits <= eb;
      done_count    <= c;
      @(posedge clk);
      done_stb <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // word offered to the port, held until it is taken
   task automatic offer(input logic [15:0] w);
      src_data  <= w;
      src_valid <= 1'b1;
      do @(posedge clk); while (src_ready !== 1'b1);
      src_valid <= 1'b0;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(0, 7, 16'h0050, "status");
      rd(0, 1, 16'h0001, "error");
      rd(0, 2, 16'h0001, "count");
      rd(0, 6, 16'h00a0, "devhead");
      wr(0, 1, 16'h005a);
      check("feature", {8'h0, feature}, 16'h005a);
      wr(1, 6, 16'h0008);
      wr(0, 6, 16'h0045);
      rd(0, 6, 16'h00e5, "devhead");
      check("lba", {15'h0, lba_mode}, 16'h0001);
      rd(1, 7, 16'h006a, "drvaddr");
      write_gate <= 1'b1;
      rd(1, 7, 16'h002a, "drvaddr");
      write_gate <= 1'b0;
      wr(0, 2, 16'h0000);
      check("xfer", {7'h0, xfer_sectors}, 16'h0100);
      wr(0, 7, 16'h0020);
      check("cmd", {8'h0, cmd_code}, 16'h0020);
      check("stb", 16'(stb_cnt), 16'h0001);
      done(1'b1, 8'hff, 8'h03);
      seek_done <= 1'b0;
      check("intrq", {15'h0, intrq}, 16'h0001);
      rd(0, 1, 16'h00d7, "error");
      rd(0, 2, 16'h0003, "count");
      rd(0, 3, 16'h0044, "sector");
      check("sectnum", {8'h0, sect_num}, 16'h0044);
      rd(0, 6, 16'h00e9, "devhead");
      rd(0, 7, 16'h0051, "status");
      check("intrq", {15'h0, intrq}, 16'h0000);
      rd(0, 7, 16'h0041, "status");
      seek_done <= 1'b1;
      wr(0, 7, 16'h0020);
      rd(0, 7, 16'h0050, "status");
      core_busy <= 1'b1;
      rd(0, 1, 16'h00d0, "busy");
      core_busy <= 1'b0;
      done(1'b0, 8'h00, 8'h00);
      rd(0, 2, 16'h0000, "count");
      wr(1, 6, 16'h000a);
      check("intrq", {15'h0, intrq}, 16'h0000);
      wr(1, 6, 16'h0008);
      check("intrq", {15'h0, intrq}, 16'h0001);
      wr(0, 6, 16'h0050);
      check("intrq", {15'h0, intrq}, 16'h0000);
      wr(0, 6, 16'h0040);
      rd(0, 7, 16'h0050, "status");
      seek_done   <= 1'b0;
      standby     <= 1'b1;
      index_pulse <= 1'b1;
      rd(1, 6, 16'h0052, "altstatus");
      standby     <= 1'b0;
      index_pulse <= 1'b0;
      rd(1, 6, 16'h0040, "altstatus");
      seek_done <= 1'b1;
      fault_evt <= 1'b1;
      @(posedge clk);
      fault_evt <= 1'b0;
      rd(0, 7, 16'h0070, "status");
      rd(0, 7, 16'h0050, "status");
      diag_stb <= 1'b1;
      @(posedge clk);
      diag_stb <= 1'b0;
      rd(0, 1, 16'h0081, "error");
      wr(1, 6, 16'h000c);
      check("soft_reset_bit", {15'h0, soft_reset}, 16'h0001);
      i_host.hold_reset();
      wr(1, 6, 16'h0008);
      rd(0, 3, 16'h0001, "sector");
      rd(0, 6, 16'h00a0, "devhead");
      rd(0, 1, 16'h0001, "error");
      xfer_en <= 1'b1;
      to_host <= 1'b1;
      offer(16'h1234);
      rd(0, 7, 16'h0058, "status");
      rd(0, 0, 16'h1234, "data");
      rd(0, 7, 16'h0050, "status");
      byte_mode <= 1'b1;
      offer(16'habcd);
      rd(0, 0, 16'h00cd, "data");
      byte_mode  <= 1'b0;
      to_host    <= 1'b0;
      sink_ready <= 1'b1;
      wr(0, 0, 16'hbeef);
      check("sink", sink_cap, 16'hbeef);
      xfer_en <= 1'b0;
      tally_and_finish();
   end
endmodule
